// file: src/cjc_exec.v
// compare-branch and clear instruction executor with its own operand state
`timescale 1ns/1ps
`default_nettype none
`include "cjc_consts.vh"

module cjc_exec #(
  parameter PC_W   = 16,
  parameter RAM_AW = 7
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              ce,
  input  wire              run,
  input  wire [7:0]        pm_data,
  input  wire              ld_ram_en,
  input  wire [RAM_AW-1:0] ld_ram_addr,
  input  wire [7:0]        ld_ram_data,
  input  wire              ld_acc_en,
  input  wire [7:0]        ld_acc_data,
  input  wire              ld_psw_en,
  input  wire [7:0]        ld_psw_data,
  output reg  [PC_W-1:0]   pm_addr_r,
  output reg  [PC_W-1:0]   pc_r,
  output reg  [7:0]        acc_r,
  output reg  [7:0]        psw_r,
  output reg  [7:0]        port_latch_r,
  output reg               instr_done_r,
  output reg               illegal_op_r
);

  // one-hot states; a stray code falls back to opcode fetch
  localparam [4:0] ST_OP   = 5'b00001;
  localparam [4:0] ST_IMM  = 5'b00010;
  localparam [4:0] ST_REL  = 5'b00100;
  localparam [4:0] ST_EXEC = 5'b01000;
  localparam [4:0] ST_BIT  = 5'b10000;

  reg [4:0]        state_r;
  reg [7:0]        op_r;
  reg [7:0]        imm_r;
  reg [7:0]        rel_r;
  // data memory; working registers live in its first eight bytes
  reg [7:0]        ram [0:(1<<RAM_AW)-1];

  wire             is_cj_acc_in = (pm_data == `CJC_OP_CJ_ACC);
  wire             is_cj_reg_in = (pm_data[7:3] == `CJC_OP_CJ_REG_HI);
  wire             is_cj_ind_in = (pm_data[7:1] == `CJC_OP_CJ_IND_HI);
  wire             is_cj_in     = is_cj_acc_in | is_cj_reg_in | is_cj_ind_in;

  wire             is_cj_acc = (op_r == `CJC_OP_CJ_ACC);
  wire             is_cj_reg = (op_r[7:3] == `CJC_OP_CJ_REG_HI);
  wire             is_cj_ind = (op_r[7:1] == `CJC_OP_CJ_IND_HI);
  wire             is_cj     = is_cj_acc | is_cj_reg | is_cj_ind;

  // clear forms; the bit form is spotted at fetch since it needs its own state
  wire             is_clr_bit_in = (pm_data == `CJC_OP_CLR_BIT);
  wire             is_clr_acc    = (op_r == `CJC_OP_CLR_ACC);
  wire             is_clr_cy     = (op_r == `CJC_OP_CLR_CY);

  // pointer byte above the array size is folded, the data memory is small
  wire [7:0]        ptr_val  = ram[{{(RAM_AW-1){1'b0}}, op_r[0]}];
  wire [RAM_AW-1:0] ind_addr = ptr_val[RAM_AW-1:0];
  wire [7:0]        reg_val  = ram[{{(RAM_AW-3){1'b0}}, op_r[2:0]}];
  wire [7:0]        ind_val  = ram[ind_addr];
  wire [7:0]        cmp_lhs  = is_cj_acc ? acc_r : (is_cj_reg ? reg_val : ind_val);

  wire             cmp_ne;
  wire             cmp_lt;
  wire [PC_W-1:0]  cmp_next;
  wire [PC_W-1:0]  cmp_target;

  cjc_cmp_branch #(
    .PC_W    (PC_W)
  ) u_cmp (
    .lhs     (cmp_lhs),
    .rhs     (imm_r),
    .pc_base (pc_r),
    .rel     (rel_r),
    .ne      (cmp_ne),
    .lt      (cmp_lt),
    .pc_next (cmp_next),
    .target  (cmp_target)
  );

  // bit space: low half is bit-addressable ram, high half special bytes
  wire             bit_in_ram  = ~pm_data[7];
  wire [2:0]       bit_pos     = pm_data[2:0];
  wire [6:0]       bit_ram_a7  = `CJC_BITRAM_BASE + {3'h0, pm_data[6:3]};
  wire [RAM_AW-1:0] bit_ram_a  = bit_ram_a7[RAM_AW-1:0];
  wire [4:0]       bit_sfr     = pm_data[7:3];
  wire [7:0]       bit_mask_n  = ~(8'h01 << bit_pos);
  wire             bit_ram_we  = (state_r == ST_BIT) & bit_in_ram;

  // special-byte targets; any other byte in the high half is left alone
  wire             bit_to_acc  = (bit_sfr == `CJC_SFR_ACC);
  wire             bit_to_psw  = (bit_sfr == `CJC_SFR_PSW);
  wire             bit_to_port = (bit_sfr == `CJC_SFR_PORT);

  // clear forms retire from pc_r, not from the fetch address, so a fetch
  // that ran ahead cannot skew the counter
  wire [PC_W-1:0]  pc_plus1 = pc_r + {{(PC_W-2){1'b0}}, `CJC_LEN_ONE};
  wire [PC_W-1:0]  pc_plus2 = pc_r + {{(PC_W-2){1'b0}}, `CJC_LEN_CLR_BIT};

  // no reset on the array: it is preset through the load port before use
  // exec write wins over a simultaneous load to keep the instruction atomic
  always @(posedge clk_sys) begin
    if (ce) begin
      if (bit_ram_we) begin
        ram[bit_ram_a] <= ram[bit_ram_a] & bit_mask_n;
      end else if (ld_ram_en) begin
        ram[ld_ram_addr] <= ld_ram_data;
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r      <= ST_OP;
      op_r         <= 8'h00;
      imm_r        <= 8'h00;
      rel_r        <= 8'h00;
      pm_addr_r    <= `CJC_RST_PC;
      pc_r         <= `CJC_RST_PC;
      acc_r        <= `CJC_RST_ACC;
      psw_r        <= `CJC_RST_PSW;
      port_latch_r <= `CJC_RST_PORT;
      instr_done_r <= 1'b0;
      illegal_op_r <= 1'b0;
    end else if (ce) begin
      instr_done_r <= 1'b0;
      illegal_op_r <= 1'b0;
      // loads land first; an instruction result on the same edge overrides them
      if (ld_acc_en) begin
        acc_r <= ld_acc_data;
      end
      if (ld_psw_en) begin
        psw_r <= ld_psw_data;
      end
      case (state_r)
        ST_OP: begin
          // opcode taken only here; ST_IMM, ST_REL and ST_BIT consume operand bytes, ST_EXEC reads none
          if (run) begin
            op_r      <= pm_data;
            pm_addr_r <= pm_addr_r + {{(PC_W-2){1'b0}}, `CJC_LEN_ONE};
            if (is_cj_in) begin
              state_r <= ST_IMM;
            end else if (is_clr_bit_in) begin
              state_r <= ST_BIT;
            end else begin
              state_r <= ST_EXEC;
            end
          end
        end
        ST_IMM: begin
          // immediate kept raw, compared unsigned in the exec state
          imm_r     <= pm_data;
          pm_addr_r <= pm_addr_r + {{(PC_W-2){1'b0}}, `CJC_LEN_ONE};
          state_r   <= ST_REL;
        end
        ST_REL: begin
          // displacement kept raw; sign extension happens in the compare unit
          rel_r     <= pm_data;
          pm_addr_r <= pm_addr_r + {{(PC_W-2){1'b0}}, `CJC_LEN_ONE};
          state_r   <= ST_EXEC;
        end
        ST_EXEC: begin
          instr_done_r <= 1'b1;
          state_r      <= ST_OP;
          if (is_cj) begin
            // operands are only read here, never written back
            psw_r[`CJC_PSW_CY_POS] <= cmp_lt;
            pc_r      <= cmp_ne ? cmp_target : cmp_next;
            // fetch follows the counter so the next opcode comes from the target when taken, else from cmp_next
            pm_addr_r <= cmp_ne ? cmp_target : cmp_next;
          end else begin
            pc_r      <= pc_plus1;
            pm_addr_r <= pc_plus1;
            if (is_clr_acc) begin
              // no flag logic on this path, the status byte keeps its value
              acc_r <= 8'h00;
            end else if (is_clr_cy) begin
              psw_r[`CJC_PSW_CY_POS] <= 1'b0;
            end else begin
              // anything else is skipped as a one-byte no-op
              illegal_op_r <= 1'b1;
            end
          end
        end
        ST_BIT: begin
          instr_done_r <= 1'b1;
          state_r      <= ST_OP;
          pc_r         <= pc_plus2;
          pm_addr_r    <= pc_plus2;
          // bit address is this cycle's fetch byte; ram targets are written above
          if (!bit_in_ram) begin
            if (bit_to_acc) begin
              acc_r <= acc_r & bit_mask_n;
            end else if (bit_to_psw) begin
              psw_r <= psw_r & bit_mask_n;
            end else if (bit_to_port) begin
              port_latch_r <= port_latch_r & bit_mask_n;
            end
          end
        end
        default: begin
          state_r <= ST_OP;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: src/cjc_consts.vh
// opcode encodings, bit-space addresses, reset values and timing for the executor
`ifndef CJC_CONSTS_VH
`define CJC_CONSTS_VH

`define CJC_OP_CJ_ACC      8'hB4
`define CJC_OP_CJ_REG_HI   5'h17
`define CJC_OP_CJ_IND_HI   7'h5B
`define CJC_OP_CLR_ACC     8'hE4
`define CJC_OP_CLR_CY      8'hC3
`define CJC_OP_CLR_BIT     8'hC2

`define CJC_LEN_CJ         2'h3
`define CJC_LEN_CLR_BIT    2'h2
`define CJC_LEN_ONE        2'h1

`define CJC_BITRAM_BASE    7'h20
`define CJC_SFR_ACC        5'h1C
`define CJC_SFR_PSW        5'h1A
`define CJC_SFR_PORT       5'h12
`define CJC_PSW_CY_POS     7

`define CJC_RST_PC         16'h0000
`define CJC_RST_ACC        8'h00
`define CJC_RST_PSW        8'h00
`define CJC_RST_PORT       8'hFF

`define CJC_CLK_PER_MC     2

`endif

// file: src/cjc_cmp_branch.v
// unsigned byte compare and relative branch target for the compare-branch forms
`timescale 1ns/1ps
`default_nettype none
`include "cjc_consts.vh"

module cjc_cmp_branch #(
  parameter PC_W = 16
) (
  input  wire [7:0]      lhs,
  input  wire [7:0]      rhs,
  input  wire [PC_W-1:0] pc_base,
  input  wire [7:0]      rel,
  output wire            ne,
  output wire            lt,
  output wire [PC_W-1:0] pc_next,
  output wire [PC_W-1:0] target
);

  assign ne      = (lhs != rhs);
  assign lt      = (lhs < rhs);
  assign pc_next = pc_base + {{(PC_W-2){1'b0}}, `CJC_LEN_CJ};
  // displacement is applied to the already advanced counter
  assign target  = pc_next + {{(PC_W-8){rel[7]}}, rel};

endmodule
`default_nettype wire

// file: dv/cjc_pmem.sv
// program memory model for the executor bench
`timescale 1ns/1ps
`default_nettype none
module cjc_pmem (
  input  wire logic [15:0] addr,
  output logic      [7:0]  data
);
  logic [7:0] mem [0:255];
  // low byte only: bench programs start at zero and stay short
  assign data = mem[addr[7:0]];
endmodule
`default_nettype wire

// file: dv/cjc_exec_asserts.sv
// concurrent checks on the executor ports
`timescale 1ns/1ps
`default_nettype none
module cjc_exec_asserts #(parameter PC_W = 16) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic            ce,
  input wire logic            run,
  input wire logic [7:0]      pm_data,
  input wire logic [PC_W-1:0] pm_addr_r,
  input wire logic [PC_W-1:0] pc_r,
  input wire logic [7:0]      acc_r,
  input wire logic [7:0]      psw_r,
  input wire logic [7:0]      port_latch_r,
  input wire logic            instr_done_r
);
  logic wait_r;
  // fetch state seen from outside; assumes ce held high
  wire  take = ce & run & (wait_r | instr_done_r);
  wire  cj_a = take && pm_data == 8'hB4;
  always @(posedge clk_sys or posedge rst)
    if (rst) wait_r <= 1'b1;
    else if (ce) wait_r <= (wait_r | instr_done_r) & ~run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_cmp_timing: assert property (take && (pm_data == 8'hB4 || pm_data[7:1] == 7'h5B ||
    pm_data[7:3] == 5'h17) |-> ##1 !instr_done_r [*3] ##1 instr_done_r) else $error("cmp timing");
  chk_cmp_branch: assert property (cj_a |-> ##4 pc_r == PC_W'($past(pm_addr_r, 4) + 3 +
    (($past(acc_r, 4) != $past(pm_data, 3)) ?
    $past(pm_data, 2) - ($past(pm_data, 2) > 127 ? 256 : 0) : 0))) else $error("cmp target");
  chk_cmp_carry: assert property (cj_a |-> ##4 psw_r[7] == ($past(acc_r, 4) < $past(pm_data, 3))
    && acc_r == $past(acc_r, 4)) else $error("cmp carry");
  chk_clr_acc: assert property (take && pm_data == 8'hE4 |-> ##2 instr_done_r
    && acc_r == 8'h00 && psw_r == $past(psw_r, 2)) else $error("acc clear");
  chk_clr_carry: assert property (take && pm_data == 8'hC3 |-> ##2 instr_done_r
    && psw_r == ($past(psw_r, 2) & 8'h7F)) else $error("carry clear");
  chk_bit_len: assert property (take && pm_data == 8'hC2 |-> ##2 instr_done_r
    && pc_r == PC_W'($past(pm_addr_r, 2) + 2)) else $error("bit clear length");
  chk_bit_port: assert property (take && pm_data == 8'hC2 ##1 pm_data[7:3] == 5'h12 |-> ##1
    port_latch_r == ($past(port_latch_r, 2) & ~(8'h01 << ($past(pm_data, 1) & 8'h07))))
    else $error("port bit clear");
  chk_bit_carry: assert property (take && pm_data == 8'hC2 ##1 pm_data == 8'hD7 |-> ##1
    psw_r == ($past(psw_r, 2) & 8'h7F) && acc_r == $past(acc_r, 2)) else $error("carry bit");
endmodule
bind cjc_exec cjc_exec_asserts #(.PC_W(PC_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .run(run), .pm_data(pm_data), .pm_addr_r(pm_addr_r), .pc_r(pc_r), .acc_r(acc_r),
  .psw_r(psw_r), .port_latch_r(port_latch_r), .instr_done_r(instr_done_r));
`default_nettype wire

// file: dv/cjc_exec_tb_top.sv
// testbench for the compare-branch and clear executor
`timescale 1ns/1ps
`default_nettype none
module cjc_exec_tb_top;
  logic        clk_sys, rst, ce, run, ld_ram_en, ld_acc_en, ld_psw_en, instr_done_r;
  logic        illegal_op_r;
  logic [6:0]  ld_ram_addr;
  logic [7:0]  ld_ram_data, ld_acc_data, ld_psw_data, pm_data, acc_r, psw_r, port_latch_r;
  logic [15:0] pm_addr_r, pc_r;
  int          mismatches, checked;
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  cjc_pmem u_pm (.addr(pm_addr_r), .data(pm_data));
  cjc_exec dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .run(run), .pm_data(pm_data),
    .ld_ram_en(ld_ram_en), .ld_ram_addr(ld_ram_addr), .ld_ram_data(ld_ram_data),
    .ld_acc_en(ld_acc_en), .ld_acc_data(ld_acc_data), .ld_psw_en(ld_psw_en),
    .ld_psw_data(ld_psw_data), .pm_addr_r(pm_addr_r), .pc_r(pc_r), .acc_r(acc_r),
    .psw_r(psw_r), .port_latch_r(port_latch_r), .instr_done_r(instr_done_r),
    .illegal_op_r(illegal_op_r));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  // caller holds ld_ram_en high across a burst so it never toggles in one step
  task automatic ram(logic [6:0] a, logic [7:0] d);
    ld_ram_addr = a;
    ld_ram_data = d;
    tick();
  endtask
  task automatic reset_load(logic [7:0] a, logic [7:0] p);
    rst = 1;
    repeat (20) tick();
    rst = 0;
    ld_acc_en = 1;
    ld_acc_data = a;
    ld_psw_en = 1;
    ld_psw_data = p;
    tick();
    ld_acc_en = 0;
    ld_psw_en = 0;
  endtask
  task automatic step();
    int n;
    run = 1;
    tick();
    run = 0;
    for (n = 0; n < 8 && instr_done_r !== 1'b1; n++) tick();
    chk("done", {15'h0, instr_done_r}, 16'h1);
  endtask
  task automatic go(logic [7:0] op, logic [7:0] b1, logic [7:0] b2);
    u_pm.mem[0] = op;
    u_pm.mem[1] = b1;
    u_pm.mem[2] = b2;
    step();
  endtask
  task automatic t_cmp(logic [7:0] op, logic [7:0] v, logic [7:0] i, logic [7:0] r);
    logic [15:0] pc;
    pc = 16'h3 + ((v != i) ? {{8{r[7]}}, r} : 16'h0);
    reset_load(v, 8'h7F);
    // only the pointer that the opcode selects reaches the matching byte
    ld_ram_en = 1;
    ram(7'h00, 8'h40);
    ram(7'h01, 8'h41);
    ram(7'h03, v);
    ram({6'h20, op[0]}, v);
    ram({6'h20, ~op[0]}, ~v);
    ld_ram_en = 0;
    go(op, i, r);
    chk("pc", pc_r, pc);
    chk("fetch", pm_addr_r, pc);
    chk("status", {8'h00, psw_r}, {8'h00, v < i, 7'h7F});
    chk("acc", {8'h00, acc_r}, {8'h00, v});
  endtask
  task automatic t_clr(logic [7:0] op, logic [7:0] b, logic [7:0] ea, logic [7:0] ep,
                       logic [7:0] eo, logic [15:0] pc);
    reset_load(8'h5C, 8'hFF);
    go(op, b, 8'h00);
    chk("acc", {8'h00, acc_r}, {8'h00, ea});
    chk("status", {8'h00, psw_r}, {8'h00, ep});
    chk("port", {8'h00, port_latch_r}, {8'h00, eo});
    chk("pc", pc_r, pc);
    chk("skip", {15'h0, illegal_op_r}, 16'h0);
  endtask
  // bit clear in the ram half, read back through an indirect compare
  task automatic t_bitram();
    reset_load(8'h00, 8'h00);
    ld_ram_en = 1;
    ram(7'h00, 8'h2A);
    ram(7'h2A, 8'hFF);
    ld_ram_en = 0;
    u_pm.mem[3] = 8'hFD;
    u_pm.mem[4] = 8'h10;
    go(8'hC2, 8'h51, 8'hB6);
    chk("bit pc", pc_r, 16'h0002);
    step();
    chk("ram bit", pc_r, 16'h0005);
    chk("ram carry", {8'h00, psw_r}, 16'h0000);
  endtask
  task automatic t_skip();
    reset_load(8'h5C, 8'hFF);
    go(8'hA5, 8'h00, 8'h00);
    chk("skip flag", {15'h0, illegal_op_r}, 16'h1);
    chk("skip acc", {8'h00, acc_r}, 16'h005C);
    chk("skip pc", pc_r, 16'h0001);
  endtask
  // enable low must swallow both a fetch request and a load
  task automatic t_freeze();
    reset_load(8'h5C, 8'hFF);
    u_pm.mem[0] = 8'hE4;
    tick();
    ce = 0;
    run = 1;
    ld_acc_en = 1;
    ld_acc_data = 8'h00;
    repeat (2) tick();
    ce = 1;
    run = 0;
    ld_acc_en = 0;
    tick();
    chk("frozen acc", {8'h00, acc_r}, 16'h005C);
    chk("frozen fetch", pm_addr_r, 16'h0000);
    chk("frozen done", {15'h0, instr_done_r}, 16'h0);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst = 1;
    ce = 1;
    run = 0;
    ld_ram_en = 0;
    ld_acc_en = 0;
    ld_psw_en = 0;
    ld_ram_addr = 7'h00;
    ld_ram_data = 8'h00;
    ld_acc_data = 8'h00;
    ld_psw_data = 8'h00;
    mismatches = 0;
    checked = 0;
    t_cmp(8'hB4, 8'h34, 8'h34, 8'h10);
    t_cmp(8'hB4, 8'h34, 8'h60, 8'hF0);
    t_cmp(8'hBB, 8'hC0, 8'h40, 8'h7F);
    t_cmp(8'hB6, 8'h00, 8'hFF, 8'h05);
    t_cmp(8'hB7, 8'hFF, 8'h00, 8'h80);
    t_clr(8'hE4, 8'h00, 8'h00, 8'hFF, 8'hFF, 16'h1);
    t_clr(8'hC3, 8'h00, 8'h5C, 8'h7F, 8'hFF, 16'h1);
    t_clr(8'hC2, 8'hD7, 8'h5C, 8'h7F, 8'hFF, 16'h2);
    t_clr(8'hC2, 8'hE3, 8'h54, 8'hFF, 8'hFF, 16'h2);
    t_clr(8'hC2, 8'h92, 8'h5C, 8'hFF, 8'hFB, 16'h2);
    t_bitram();
    t_skip();
    t_freeze();
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
